// ==== hdl/pwsd_pkg.sv ====
package pwsd_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_AUTOSHUTDOWN = 8'h00;
  localparam logic [7:0] OFS_ENH_PWM = 8'h04;
  localparam logic [7:0] OFS_STEERING = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam int ADDR_BITS = 8;

  // Reset values
  localparam logic [7:0] RST_AUTOSHUTDOWN = 8'h00;
  localparam logic [7:0] RST_ENH_PWM = 8'h00;
  localparam logic [4:0] RST_STEERING = 5'h01;
  localparam logic [5:0] RST_MODE = 6'h00;

  // Autoshutdown control fields
  localparam int AS_FLAG_BIT = 7;
  localparam int AS_SRC_LSB = 4;
  localparam int AS_AC_LSB = 2;
  localparam int AS_BD_LSB = 0;
  // Enhanced PWM control fields
  localparam int EP_RESTART_BIT = 7;
  localparam int EP_DELAY_LSB = 0;
  localparam int DELAY_BITS = 7;
  // Steering control fields
  localparam int ST_SYNC_BIT = 4;
  localparam int ST_ENABLE_LSB = 0;
  localparam int ST_BITS = 5;
  // Mode register fields: ccp_mode_field [3:0], pwm_output_config [5:4]
  localparam int MD_MODE_LSB = 0;
  localparam int MD_CFG_LSB = 4;
  localparam int MD_BITS = 6;

  localparam logic [1:0] MODE_PWM_HI = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_HALF = 2'h2;

  // Shutdown pin states
  localparam logic [1:0] SHUT_DRIVE_LOW = 2'h0;
  localparam logic [1:0] SHUT_DRIVE_HIGH = 2'h1;
  localparam logic [1:0] SHUT_FLOAT = 2'h2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Four PWM pins, index 0..3 = pin A..D
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pwsd_pins_type;
endpackage : pwsd_pkg

// ==== hdl/pwsd_output_stage.sv ====
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Bit 7 flag shows shutdown state
// - Three-bit select picks comparator/pin sources
// - Pair A/C shutdown: low, high, float
// - Pair B/D shutdown: low, high, float
// - Shutdown is level sensitive, persists
// - Flag writes ignored while condition present
// - Resume only at next period start
// - Software writing flag forces shutdown
// - Auto restart also clears a software-set flag
// - Auto restart clears flag when condition gone
// - Dead band delays only inactive-to-active edges
// - Seven-bit count sets delay cycles
// - Steering only in single-output mode
// - Four enables route waveform, A resets set
// - Mode low bits set steered polarity
// - Shutdown touches only PWM-owned pins (steered, or A/B in half bridge)
// - Sync bit defers steering to period
// - Steering upper three bits read zero
// - Shutdown forces pins without period wait
// - Half bridge: A true, B complement
module pwsd_output_stage (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic periodStart,
  input wire logic pwmRaw,
  input wire logic comparator1Result,
  input wire logic comparator2Result,
  input wire logic extIrq0Pin,
  input wire pwsd_pkg::pwsd_pins_type portPins,
  output pwsd_pkg::pwsd_pins_type pwmPins
);
  import pwsd_pkg::*;

  logic [7:0] asRegQ;
  logic [7:0] asRegD;
  logic [7:0] epRegQ;
  logic [7:0] epRegD;
  logic [ST_BITS-1:0] stRegQ;
  logic [ST_BITS-1:0] stRegD;
  logic [MD_BITS-1:0] mdRegQ;
  logic [MD_BITS-1:0] mdRegD;
  logic wrPendQ;
  logic [ADDR_BITS-1:0] wrAddrQ;
  logic addrPhase;
  logic busWrite;
  logic asWrite;
  logic swSetFlag;
  logic [2:0] srcSel;
  logic hwCond;
  logic autoRestart;
  logic flagD;
  logic shutQ;
  logic [3:0] steerEffQ;
  logic pwmEnabled;
  logic singleMode;
  logic halfMode;
  logic [DELAY_BITS-1:0] delayCount;
  logic [1:0] dbReq;
  logic [1:0] dbReqPrevQ;
  logic [1:0] dbRise;
  logic [1:0] dbAct;
  logic [DELAY_BITS-1:0] dbCntQ [2];
  logic [3:0] pinOwned;
  logic [3:0] pinLevelD;
  logic [3:0] pinOeD;

  // Address phase of a transfer aimed at us
  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);

  // Write data arrives one cycle after its address phase
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrPendQ <= 1'b0;
      wrAddrQ <= '0;
    end else if (hready) begin
      wrPendQ <= addrPhase & hwrite;
      wrAddrQ <= haddr[ADDR_BITS-1:0];
    end
  end

  assign busWrite = wrPendQ;
  assign asWrite = busWrite & (wrAddrQ == OFS_AUTOSHUTDOWN);
  assign swSetFlag = asWrite & hwdata[AS_FLAG_BIT];

  // Shutdown source decode
  assign srcSel = asRegQ[AS_SRC_LSB +: 3];
  assign hwCond = (srcSel[0] & comparator1Result)
                | (srcSel[1] & comparator2Result)
                | (srcSel[2] & ~extIrq0Pin);
  assign autoRestart = epRegQ[EP_RESTART_BIT];

  // Flag next value: hardware set beats any write or clear
  always_comb begin
    if (hwCond) begin
      flagD = 1'b1;
    end else if (autoRestart) begin
      flagD = 1'b0;
    end else if (asWrite) begin
      flagD = hwdata[AS_FLAG_BIT];
    end else begin
      flagD = asRegQ[AS_FLAG_BIT];
    end
  end

  // Register next values; unimplemented steering bits never stored
  always_comb begin
    asRegD = asRegQ;
    epRegD = epRegQ;
    stRegD = stRegQ;
    mdRegD = mdRegQ;
    if (busWrite) begin
      case (wrAddrQ)
        OFS_AUTOSHUTDOWN: asRegD = hwdata[7:0];
        OFS_ENH_PWM: epRegD = hwdata[7:0];
        OFS_STEERING: stRegD = hwdata[ST_BITS-1:0];
        OFS_MODE: mdRegD = hwdata[MD_BITS-1:0];
        default: asRegD = asRegQ;
      endcase
    end
    asRegD[AS_FLAG_BIT] = flagD;
  end

  // Control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      asRegQ <= RST_AUTOSHUTDOWN;
      epRegQ <= RST_ENH_PWM;
      stRegQ <= RST_STEERING;
      mdRegQ <= RST_MODE;
    end else begin
      asRegQ <= asRegD;
      epRegQ <= epRegD;
      stRegQ <= stRegD;
      mdRegQ <= mdRegD;
    end
  end

  // Read data from next values so a write is seen by a read right behind it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (addrPhase & ~hwrite) begin
      case (haddr[ADDR_BITS-1:0])
        OFS_AUTOSHUTDOWN: hrdata <= {24'h000000, asRegD};
        OFS_ENH_PWM: hrdata <= {24'h000000, epRegD};
        OFS_STEERING: hrdata <= {27'h0000000, stRegD};
        OFS_MODE: hrdata <= {26'h0000000, mdRegD};
        default: hrdata <= '0;
      endcase
    end
  end

  // Outputs stay held from the first set until a clean period start
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shutQ <= 1'b0;
    end else if (hwCond | swSetFlag | asRegQ[AS_FLAG_BIT]) begin
      shutQ <= 1'b1;
    end else if (periodStart) begin
      shutQ <= 1'b0;
    end
  end

  // Mode decode
  assign pwmEnabled = (mdRegQ[MD_MODE_LSB+2 +: 2] == MODE_PWM_HI);
  assign singleMode = pwmEnabled & (mdRegQ[MD_CFG_LSB +: 2] == CFG_SINGLE);
  assign halfMode = pwmEnabled & (mdRegQ[MD_CFG_LSB +: 2] == CFG_HALF);
  assign delayCount = epRegQ[EP_DELAY_LSB +: DELAY_BITS];

  // Steering takes effect now, or only at the period start when synced
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      steerEffQ <= RST_STEERING[3:0];
    end else if (!stRegQ[ST_SYNC_BIT] | periodStart) begin
      steerEffQ <= stRegQ[ST_ENABLE_LSB +: 4];
    end
  end

  // Half-bridge requests: true on A, complement on B
  assign dbReq = {~pwmRaw, pwmRaw};

  // Dead-band delay per half-bridge output
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_deadband
      assign dbRise[ch] = dbReq[ch] & ~dbReqPrevQ[ch];
      // Falling edges pass at once; rising edges wait out the count
      assign dbAct[ch] = dbReq[ch] & (dbRise[ch] ? (delayCount == '0)
                                                 : (dbCntQ[ch] == '0));
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          dbReqPrevQ[ch] <= 1'b0;
          dbCntQ[ch] <= '0;
        end else begin
          dbReqPrevQ[ch] <= dbReq[ch];
          if (dbRise[ch]) begin
            // Restart on every new request
            dbCntQ[ch] <= (delayCount == '0) ? '0 : delayCount - 1'b1;
          end else if (dbCntQ[ch] != '0) begin
            dbCntQ[ch] <= dbCntQ[ch] - 1'b1;
          end
        end
      end
    end
  endgenerate

  // Pin composition: shutdown state, PWM drive or port control
  generate
    for (genvar p = 0; p < 4; p++) begin : g_pin
      localparam int STATE_LSB = (p % 2 == 0) ? AS_AC_LSB : AS_BD_LSB;
      localparam int POL_BIT = (p % 2 == 0) ? MD_MODE_LSB + 1 : MD_MODE_LSB;
      logic activeRaw;
      logic [1:0] shutState;
      assign pinOwned[p] = singleMode ? steerEffQ[p] : (halfMode && p < 2);
      assign activeRaw = singleMode ? pwmRaw : dbAct[p % 2];
      assign shutState = asRegQ[STATE_LSB +: 2];
      always_comb begin
        if (pinOwned[p] & shutQ) begin
          // Only owned pins are forced; reserved code floats the pin
          pinLevelD[p] = (shutState == SHUT_DRIVE_HIGH);
          pinOeD[p] = (shutState == SHUT_DRIVE_LOW) | (shutState == SHUT_DRIVE_HIGH);
        end else if (pinOwned[p]) begin
          pinLevelD[p] = activeRaw ^ mdRegQ[POL_BIT];
          pinOeD[p] = 1'b1;
        end else begin
          pinLevelD[p] = portPins.level[p];
          pinOeD[p] = portPins.oe[p];
        end
      end
    end
  endgenerate

  // Registered pins; one clock of latency even on shutdown
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwmPins <= '0;
    end else begin
      pwmPins.level <= pinLevelD;
      pwmPins.oe <= pinOeD;
    end
  end

  // Checks
  sequence s_rise_two;
    dbRise[0] && (delayCount == 7'h02) ##1 dbReq[0];
  endsequence

  sequence s_rise_two_held;
    s_rise_two ##1 dbReq[0];
  endsequence

  a_flag_hw_set: assert property (@(posedge mclk) disable iff (!rst_n)
    hwCond |=> asRegQ[AS_FLAG_BIT]) else $error("flag not set by source");

  a_write_blocked: assert property (@(posedge mclk) disable iff (!rst_n)
    hwCond && asWrite && !hwdata[AS_FLAG_BIT] |=> asRegQ[AS_FLAG_BIT])
    else $error("flag cleared during condition");

  a_resume_period: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(shutQ) |-> $past(periodStart)) else $error("resume off period");

  a_sw_shutdown: assert property (@(posedge mclk) disable iff (!rst_n)
    swSetFlag |=> shutQ) else $error("software shutdown missed");

  a_auto_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    autoRestart && !hwCond |=> !asRegQ[AS_FLAG_BIT])
    else $error("auto restart kept flag");

  a_db_waiting: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rise_two |-> !dbAct[0]) else $error("dead band too short");

  a_db_done: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rise_two_held |-> dbAct[0]) else $error("dead band too long");

  a_fall_undelayed: assert property (@(posedge mclk) disable iff (!rst_n)
    !dbReq[0] |-> !dbAct[0]) else $error("inactive edge delayed");

  a_steer_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    stRegQ[ST_SYNC_BIT] && !periodStart |=> $stable(steerEffQ))
    else $error("steering changed mid period");

  a_shut_float: assert property (@(posedge mclk) disable iff (!rst_n)
    shutQ && pinOwned[0] && asRegQ[AS_AC_LSB +: 2] == SHUT_FLOAT |=> !pwmPins.oe[0])
    else $error("pin A not floated");

endmodule : pwsd_output_stage

// ==== tb/pwsd_switch_model.sv ====
`timescale 1ns/1ps
module pwsd_switch_model
  import pwsd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire pwsd_pkg::pwsd_pins_type pins,
  output logic [3:0] gate
);
  logic [3:0] lastQ;
  // Last level seen at each switch input
  always_ff @(posedge mclk) begin
    lastQ <= rst_n ? gate : 4'h0;
  end
  // Released pin toggles, so a stale value never looks driven
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate[i] = pins.oe[i] ? pins.level[i] : ~lastQ[i];
    end
  end
endmodule : pwsd_switch_model

// ==== tb/pwm_shutdown_deadband_steering_test.sv ====
`timescale 1ns/1ps
module pwm_shutdown_deadband_steering_test;
  import pwsd_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic periodStart = 1'b0;
  logic pwmRaw = 1'b0;
  logic comparator1Result = 1'b0;
  logic comparator2Result = 1'b0;
  logic extIrq0Pin = 1'b1;
  pwsd_pins_type portPins = 8'h00;
  pwsd_pins_type pwmPins;
  logic [3:0] gate;
  logic [31:0] r;
  logic [7:0] e;
  logic [3:0] en;
  logic [2:0] s;
  logic hit;
  int failCount = 0;
  int checkCount = 0;

  // Free-running 40 MHz clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  pwsd_output_stage dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .periodStart(periodStart),
    .pwmRaw(pwmRaw), .comparator1Result(comparator1Result),
    .comparator2Result(comparator2Result), .extIrq0Pin(extIrq0Pin), .portPins(portPins),
    .pwmPins(pwmPins));

  pwsd_switch_model partner (.mclk(mclk), .rst_n(rst_n), .pins(pwmPins), .gate(gate));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Bounded wait for hready, a hang ends the run
  task automatic waitReady;
    repeat (20) begin
      @(posedge mclk);
      if (hreadyout === 1'b1) return;
    end
    failCount++;
    results();
  endtask : waitReady

  // One single word transfer; read data lands in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    r = hrdata;
  endtask : bus

  task automatic period;
    periodStart <= 1'b1;
    @(posedge mclk);
    periodStart <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : period

  // Steering mode pins: steered pins carry the waveform, others the port
  function automatic logic [7:0] pinsExp(input logic [3:0] en, input logic [1:0] pol,
      input logic raw, input logic [7:0] port);
    logic [3:0] lv;
    for (int i = 0; i < 4; i++) begin
      lv[i] = en[i] ? raw ^ (i % 2 ? pol[0] : pol[1]) : port[4 + i];
    end
    return {lv, en | port[3:0]};
  endfunction : pinsExp

  initial begin
    void'($urandom(11));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(0, OFS_ENH_PWM, 0);
    check("pwm ctl", r, 32'h0);
    check("hresp okay", 32'(hresp), 32'h0);
    check("hreadyout", 32'(hreadyout), 32'h1);
    bus(0, OFS_STEERING, 0);
    check("steer", r, 32'h1);
    bus(1, OFS_STEERING, 32'hFF);
    bus(0, OFS_STEERING, 0);
    check("steer top", r, 32'h1F);
    bus(0, 8'h10, 0);
    check("unmapped", r, 32'h0);
    $display("registers done");
    // Every nonzero source code twice with random source levels; flag cleared after the sources are released
    for (int i = 0; i < 14; i++) begin
      s = 3'(i % 7 + 1);
      e = 8'($urandom);
      comparator1Result <= e[0];
      comparator2Result <= e[1];
      extIrq0Pin <= e[2];
      hit = (s[0] & e[0]) | (s[1] & e[1]) | (s[2] & ~e[2]);
      bus(1, OFS_AUTOSHUTDOWN, {s, 4'h0});
      bus(0, OFS_AUTOSHUTDOWN, 0);
      check("source", r, {hit, s, 4'h0});
      comparator1Result <= 1'b0;
      comparator2Result <= 1'b0;
      extIrq0Pin <= 1'b1;
      repeat (2) @(posedge mclk);
      bus(1, OFS_AUTOSHUTDOWN, 0);
    end
    period();
    $display("sources done");
    for (int i = 0; i < 8; i++) begin
      en = 4'($urandom);
      pwmRaw <= 1'($urandom);
      portPins <= 8'($urandom);
      bus(1, OFS_MODE, 32'h0C + i % 4);
      bus(1, OFS_STEERING, 32'(en));
      // Register, effective steering and pin flop each take one edge
      repeat (3) @(posedge mclk);
      check("steered", 32'(pwmPins), 32'(pinsExp(en, 2'(i), pwmRaw, portPins)));
    end
    bus(1, OFS_STEERING, 32'h10 | 32'(~en));
    repeat (3) @(posedge mclk);
    check("sync hold", 32'(pwmPins), 32'(pinsExp(en, 2'h3, pwmRaw, portPins)));
    period();
    check("sync take", 32'(pwmPins), 32'(pinsExp(~en, 2'h3, pwmRaw, portPins)));
    $display("steering done");
    // Comparator shutdown: A/C high, B/D low, C and D left to the port
    bus(1, OFS_MODE, 32'h0C);
    bus(1, OFS_STEERING, 32'h03);
    pwmRaw <= 1'b0;
    bus(1, OFS_AUTOSHUTDOWN, 32'h14);
    comparator1Result <= 1'b1;
    repeat (3) @(posedge mclk);
    e = pinsExp(4'h3, 2'h0, 1'b0, portPins);
    e[4] = 1'b1;
    check("shut pins", 32'(pwmPins), 32'(e));
    check("switch a", 32'(gate[0]), 32'h1);
    comparator1Result <= 1'b0;
    repeat (3) @(posedge mclk);
    bus(0, OFS_AUTOSHUTDOWN, 0);
    check("flag kept", r, 32'h94);
    bus(1, OFS_AUTOSHUTDOWN, 32'h14);
    repeat (3) @(posedge mclk);
    check("no resume", 32'(pwmPins), 32'(e));
    period();
    check("resumed", 32'(pwmPins), 32'(pinsExp(4'h3, 2'h0, 1'b0, portPins)));
    // Software shutdown with B/D released, then auto restart cases
    bus(1, OFS_AUTOSHUTDOWN, 32'h96);
    repeat (2) @(posedge mclk);
    check("float b", 32'(pwmPins.oe[1]), 32'h0);
    bus(1, OFS_AUTOSHUTDOWN, 32'h9A);
    repeat (2) @(posedge mclk);
    check("float a", 32'(pwmPins.oe[0]), 32'h0);
    bus(1, OFS_AUTOSHUTDOWN, 32'h16);
    bus(1, OFS_ENH_PWM, 32'h80);
    bus(1, OFS_AUTOSHUTDOWN, 32'h96);
    bus(0, OFS_AUTOSHUTDOWN, 0);
    check("soft restart", r, 32'h16);
    comparator1Result <= 1'b1;
    bus(0, OFS_AUTOSHUTDOWN, 0);
    check("hw held", r, 32'h96);
    comparator1Result <= 1'b0;
    repeat (3) @(posedge mclk);
    bus(0, OFS_AUTOSHUTDOWN, 0);
    check("hw restart", r, 32'h16);
    $display("shutdown done");
    // Half bridge with a dead band of six cycles
    bus(1, OFS_AUTOSHUTDOWN, 0);
    bus(1, OFS_MODE, 32'h2C);
    bus(1, OFS_ENH_PWM, 32'h06);
    period();
    repeat (8) @(posedge mclk);
    pwmRaw <= 1'b1;
    repeat (2) @(posedge mclk);
    check("b falls", 32'(pwmPins.level[1:0]), 32'h0);
    repeat (2) @(posedge mclk);
    check("a waits", 32'(pwmPins.level[0]), 32'h0);
    repeat (5) @(posedge mclk);
    check("a rises", 32'(pwmPins.level[1:0]), 32'h1);
    pwmRaw <= 1'b0;
    repeat (10) @(posedge mclk);
    pwmRaw <= 1'b1;
    repeat (3) @(posedge mclk);
    pwmRaw <= 1'b0;
    hit = 1'b0;
    repeat (10) begin
      @(posedge mclk);
      hit = hit | pwmPins.level[0];
    end
    check("short pulse", 32'(hit), 32'h0);
    // Short band of two cycles
    bus(1, OFS_ENH_PWM, 32'h02);
    pwmRaw <= 1'b1;
    repeat (4) @(posedge mclk);
    check("a short band", 32'(pwmPins.level[0]), 32'h1);
    $display("dead band done");
    results();
  end
endmodule : pwm_shutdown_deadband_steering_test
